// [bench/tb_word_compare_shift_subtract.sv]
// self-checking bench of the compare, shift and subtract slice
`default_nettype none
`define WCS_CHECK(g, x) begin comparisons++; if ((g) !== (x)) begin error_cnt++; \
   $display("MISMATCH at %0t: got %0h expected %0h", $time, g, x); end end
module tb_word_compare_shift_subtract import wcs_pkg::*; ();
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0; // core clock
   logic rst_n = 1'b0; // synchronous reset
   wcs_req_t req = '0; // issue slot
   wcs_res_t res; // retired result
   logic overflow_exc; // trap pulse
   logic irq; // interrupt level
   logic [7:0] reg_addr = 8'h00; // register address
   logic [31:0] reg_wdata = 32'h0; // register write data
   logic reg_wr = 1'b0; // write strobe
   logic reg_rd = 1'b0; // read strobe
   logic [31:0] reg_rdata; // register read data
   int error_cnt = 0; // mismatches
   int comparisons = 0; // checks made
   integer seed = 32'h3F2C; // random seed
   logic en = 1'b1; // enable bit as the bench believes it
   logic [65:0] exp_q[$]; // expected write, trap and data
   logic [4:0] dst_q[$]; // expected target index per result
   logic [65:0] e; // popped expectation
   wcs_op_t o; // random op
   logic [31:0] x; // random words
   logic [31:0] y;
   wcs_slice u_wcs_slice (.clock(clock), .rst_n(rst_n), .req(req), .res(res),
      .overflow_exc(overflow_exc), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
   // 250 MHz clock
   always #2 clock = ~clock;
   // word sign extension
   function automatic logic [63:0] sx(input logic [31:0] w);
      return {{32{w[31]}}, w};
   endfunction : sx
   // reference result of one issue
   function automatic logic [65:0] model(input wcs_req_t r);
      logic [31:0] a;
      logic [31:0] b;
      logic [31:0] d;
      logic [63:0] im;
      logic v;
      a = r.first_source[31:0];
      b = r.second_source[31:0];
      im = {{48{r.immediate[15]}}, r.immediate};
      d = a - b;
      v = (a[31] != b[31]) && (d[31] != a[31]);
      case (r.op)
         WCS_OP_SIGNED_COMPARE_REGS: d = 32'($signed(r.first_source) < $signed(r.second_source));
         WCS_OP_SIGNED_COMPARE_IMM: d = 32'($signed(r.first_source) < $signed(im));
         WCS_OP_UNSIGNED_COMPARE_IMM: d = 32'(r.first_source < im);
         WCS_OP_UNSIGNED_COMPARE_REGS: d = 32'(r.first_source < r.second_source);
         WCS_OP_ARITH_RIGHT_SHIFT_FIXED: d = $signed(b) >>> r.shift_amount_field;
         WCS_OP_ARITH_RIGHT_SHIFT_VARIABLE: d = $signed(b) >>> a[4:0];
         WCS_OP_LOGICAL_RIGHT_SHIFT_FIXED: d = b >> r.shift_amount_field;
         WCS_OP_LOGICAL_RIGHT_SHIFT_VARIABLE: d = b >> a[4:0];
         WCS_OP_DIFFERENCE_TRAPPING: return {!v, v, sx(d)};
         default: d = d;
      endcase
      return {2'b10, sx(d)};
   endfunction : model
   // one issue cycle, request held until the taking edge
   task automatic issue(input wcs_op_t op, input logic [63:0] a, input logic [63:0] b,
      input logic [15:0] im, input logic [4:0] sh);
      wcs_req_t r;
      r = '{1'b1, op, a, b, im, sh, 5'($random(seed))};
      req <= r;
      if (en) begin
         exp_q.push_back(model(r));
         dst_q.push_back(r.dest_index);
      end
      @(posedge clock);
   endtask : issue
   // empty issue cycle
   task automatic idle;
      req <= '0;
      @(posedge clock);
   endtask : idle
   // register write, one strobe cycle
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      @(posedge clock);
   endtask : wr
   // register read, data checked in the following cycle
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(negedge clock);
      `WCS_CHECK(reg_rdata, x)
      @(posedge clock);
   endtask : rd
   // reset held for ten cycles
   task automatic do_reset;
      rst_n <= 1'b0;
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      exp_q.delete();
      dst_q.delete();
   endtask : do_reset
   // verdict and end of run
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_sim
   // result monitor against the reference queue
   always @(negedge clock) begin
      if (res.valid === 1'b1) begin
         e = exp_q.size() > 0 ? exp_q.pop_front() : 66'h0;
         `WCS_CHECK(res.dest_index, (dst_q.size() > 0 ? dst_q.pop_front() : 5'h0))
         `WCS_CHECK(res.write_en, e[65])
         `WCS_CHECK(overflow_exc, e[64])
         if (e[65])
            `WCS_CHECK(res.data, e[63:0])
      end else
         `WCS_CHECK(overflow_exc, 1'b0)
   end
   // watchdog
   initial begin
      #20000;
      error_cnt++;
      end_sim;
   end
   // main sequence
   initial begin
      do_reset;
      issue(WCS_OP_SIGNED_COMPARE_IMM, '1, 64'h0, 16'h0000, 5'h0);
      issue(WCS_OP_SIGNED_COMPARE_IMM, 64'h0, 64'h0, 16'h8000, 5'h0);
      issue(WCS_OP_UNSIGNED_COMPARE_IMM, 64'h7FFF, 64'h0, 16'h8000, 5'h0);
      issue(WCS_OP_UNSIGNED_COMPARE_IMM, 64'h8000, 64'h0, 16'h7FFF, 5'h0);
      issue(WCS_OP_UNSIGNED_COMPARE_REGS, 64'h1_0000_0000, 64'hFFFF_FFFF, 16'h0, 5'h0);
      issue(WCS_OP_SIGNED_COMPARE_REGS, 64'h8000_0000_0000_0000, 64'h1, 16'h0, 5'h0);
      issue(WCS_OP_ARITH_RIGHT_SHIFT_FIXED, 64'h0, sx(32'h8000_0000), 16'h0, 5'h1F);
      issue(WCS_OP_ARITH_RIGHT_SHIFT_VARIABLE, '1 ^ 64'h1B, sx(32'hF000_0000), 16'h0, 5'h0);
      issue(WCS_OP_LOGICAL_RIGHT_SHIFT_FIXED, 64'h0, sx(32'h8000_0000), 16'h0, 5'h0);
      issue(WCS_OP_LOGICAL_RIGHT_SHIFT_FIXED, 64'h0, sx(32'h8000_0000), 16'h0, 5'h1);
      issue(WCS_OP_LOGICAL_RIGHT_SHIFT_VARIABLE, 64'h3F, '1, 16'h0, 5'h0);
      issue(WCS_OP_DIFFERENCE_TRAPPING, 64'h7FFF_FFFF, '1, 16'h0, 5'h0);
      issue(WCS_OP_DIFFERENCE_TRAPPING, sx(32'h8000_0000), 64'h1, 16'h0, 5'h0);
      issue(WCS_OP_DIFFERENCE_TRAPPING, 64'h5, 64'h7, 16'h0, 5'h0);
      issue(WCS_OP_DIFFERENCE_WRAPAROUND, 64'h7FFF_FFFF, '1, 16'h0, 5'h0);
      idle;
      $display("test directed done");
      for (int i = 0; i < 300; i++) begin
         o = wcs_op_t'(4'($unsigned($random(seed)) % 10));
         x = $random(seed);
         y = $random(seed);
         issue(o, o < WCS_OP_ARITH_RIGHT_SHIFT_FIXED ? {$random(seed), x} : sx(x), sx(y),
            16'($random(seed)), 5'($random(seed)));
      end
      idle;
      $display("test random done");
      do_reset;
      rd(WCS_CTRL_OFS, 32'h1);
      rd(WCS_MASK_OFS, 32'h0);
      rd(8'h20, 32'h0);
      wr(WCS_MASK_OFS, 32'h1);
      issue(WCS_OP_DIFFERENCE_TRAPPING, 64'h7FFF_FFFF, '1, 16'h0, 5'h0);
      idle;
      @(negedge clock);
      `WCS_CHECK(irq, 1'b1)
      @(posedge clock);
      rd(WCS_STATUS_OFS, 32'h5);
      @(negedge clock);
      `WCS_CHECK(irq, 1'b0)
      @(posedge clock);
      rd(WCS_TRAPCNT_OFS, 32'h1);
      rd(WCS_OPCNT_OFS, 32'h1);
      wr(WCS_CTRL_OFS, 32'h0);
      en = 1'b0;
      issue(WCS_OP_DIFFERENCE_WRAPAROUND, 64'h1, 64'h2, 16'h0, 5'h0);
      idle;
      rd(WCS_STATUS_OFS, 32'h0);
      $display("test registers done");
      end_sim;
   end
endmodule : tb_word_compare_shift_subtract
`default_nettype wire

// [bench/wcs_slice_props.sv]
// checker of result relations at the slice ports
`default_nettype none
module wcs_slice_props
   import wcs_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // issue and result
   input wire wcs_req_t req,
   input wire wcs_res_t res,
   input wire logic overflow_exc
);
   wcs_req_t q; // issue behind the current result
   logic [31:0] a; // first source word
   logic [31:0] b; // second source word
   logic [31:0] d; // word difference
   logic [63:0] im; // sign-extended immediate
   logic v; // word overflow of the difference
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // word sign extension
   function automatic logic [63:0] sx(input logic [31:0] w);
      return {{32{w[31]}}, w};
   endfunction : sx
   // keep the issue beside its result
   always_ff @(posedge clock) begin
      if (!rst_n)
         q <= '0;
      else
         q <= req;
   end
   assign a = q.first_source[31:0];
   assign b = q.second_source[31:0];
   assign d = a - b;
   assign im = {{48{q.immediate[15]}}, q.immediate};
   assign v = (a[31] != b[31]) && (d[31] != a[31]);
   chk_imm_signed: assert property (
      res.valid && q.op == WCS_OP_SIGNED_COMPARE_IMM |->
      res.data == {63'h0, $signed(q.first_source) < $signed(im)})
      else $error("signed immediate compare wrong");
   chk_imm_unsigned: assert property (
      res.valid && q.op == WCS_OP_UNSIGNED_COMPARE_IMM |->
      res.data == {63'h0, q.first_source < im})
      else $error("unsigned immediate compare wrong");
   chk_regs_unsigned: assert property (
      res.valid && q.op == WCS_OP_UNSIGNED_COMPARE_REGS |->
      res.data == {63'h0, q.first_source < q.second_source})
      else $error("unsigned register compare wrong");
   chk_cmp_no_trap: assert property (
      q.valid && q.op <= WCS_OP_UNSIGNED_COMPARE_REGS |-> !overflow_exc)
      else $error("compare raised overflow");
   chk_asr_fixed: assert property (
      res.valid && q.op == WCS_OP_ARITH_RIGHT_SHIFT_FIXED |->
      res.data == sx($signed(b) >>> q.shift_amount_field))
      else $error("arithmetic fixed shift wrong");
   chk_lsr_var: assert property (
      res.valid && q.op == WCS_OP_LOGICAL_RIGHT_SHIFT_VARIABLE |-> res.data == sx(b >> a[4:0]))
      else $error("logical variable shift wrong");
   chk_trap_keep: assert property (
      res.valid && q.op == WCS_OP_DIFFERENCE_TRAPPING |->
      overflow_exc == v && res.write_en == !v && (v || res.data == sx(d)))
      else $error("trapping difference wrong");
   chk_wrap_write: assert property (
      res.valid && q.op == WCS_OP_DIFFERENCE_WRAPAROUND |->
      res.write_en && !overflow_exc && res.data == sx(d))
      else $error("wraparound difference wrong");
   cov_trap: cover property (overflow_exc);
   cov_asr_var: cover property (res.valid && q.op == WCS_OP_ARITH_RIGHT_SHIFT_VARIABLE);
   cov_ucmp_hit: cover property (res.valid && q.op == WCS_OP_UNSIGNED_COMPARE_IMM && res.data[0]);
endmodule : wcs_slice_props
bind wcs_slice wcs_slice_props u_wcs_slice_props (.clock(clock), .rst_n(rst_n), .req(req),
   .res(res), .overflow_exc(overflow_exc));
`default_nettype wire

// [src/wcs_pkg.sv]
// package of constants and types for the word compare, shift and subtract slice
`default_nettype none

package wcs_pkg;

   // datapath widths
   localparam int WCS_XLEN = 64;
   localparam int WCS_WLEN = 32;
   localparam int WCS_IMM_W = 16;
   localparam int WCS_SHAMT_W = 5;
   localparam int WCS_REGIDX_W = 5;
   localparam int WCS_WSIGN_BIT = 31;

   // register bus widths
   localparam int WCS_ADDR_W = 8;
   localparam int WCS_DATA_W = 32;

   // register byte offsets
   localparam logic [7:0] WCS_CTRL_OFS = 8'h00;
   localparam logic [7:0] WCS_STATUS_OFS = 8'h04;
   localparam logic [7:0] WCS_MASK_OFS = 8'h08;
   localparam logic [7:0] WCS_OPCNT_OFS = 8'h0C;
   localparam logic [7:0] WCS_TRAPCNT_OFS = 8'h10;

   // control fields
   localparam int WCS_CTRL_EN_BIT = 0;
   localparam logic WCS_CTRL_EN_RST = 1'h1;

   // status and mask fields
   localparam int WCS_EVT_W = 3;
   localparam int WCS_EVT_OVF = 0;
   localparam int WCS_EVT_BADOP = 1;
   localparam int WCS_EVT_DONE = 2;
   localparam logic [2:0] WCS_MASK_RST = 3'h0;

   // operations handled by the slice
   typedef enum logic [3:0] {
      WCS_OP_SIGNED_COMPARE_REGS,
      WCS_OP_SIGNED_COMPARE_IMM,
      WCS_OP_UNSIGNED_COMPARE_IMM,
      WCS_OP_UNSIGNED_COMPARE_REGS,
      WCS_OP_ARITH_RIGHT_SHIFT_FIXED,
      WCS_OP_ARITH_RIGHT_SHIFT_VARIABLE,
      WCS_OP_LOGICAL_RIGHT_SHIFT_FIXED,
      WCS_OP_LOGICAL_RIGHT_SHIFT_VARIABLE,
      WCS_OP_DIFFERENCE_TRAPPING,
      WCS_OP_DIFFERENCE_WRAPAROUND
   } wcs_op_t;

   // one issued operation
   typedef struct packed {
      logic valid;
      wcs_op_t op;
      logic [63:0] first_source;
      logic [63:0] second_source;
      logic [15:0] immediate;
      logic [4:0] shift_amount_field;
      logic [4:0] dest_index;
   } wcs_req_t;

   // one retired operation
   typedef struct packed {
      logic valid;
      logic write_en;
      logic [4:0] dest_index;
      logic [63:0] data;
   } wcs_res_t;

endpackage : wcs_pkg

`default_nettype wire

// [src/wcs_slice.sv]
// word compare, shift and subtract execution slice with register port
`default_nettype none

module wcs_slice
   import wcs_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // operation issue
   input wire wcs_req_t req,
   // operation result towards the register file
   output var wcs_res_t res,
   output var logic overflow_exc,
   // register port
   input wire logic [WCS_ADDR_W-1:0] reg_addr,
   input wire logic [WCS_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output var logic [WCS_DATA_W-1:0] reg_rdata,
   // interrupt
   output var logic irq
);

   // registers
   logic ctrl_en_reg; // slice enable
   logic [WCS_EVT_W-1:0] status_reg; // sticky events
   logic [WCS_EVT_W-1:0] status_next;
   logic [WCS_EVT_W-1:0] mask_reg; // interrupt mask
   logic [WCS_DATA_W-1:0] opcnt_reg; // retired operations
   logic [WCS_DATA_W-1:0] trapcnt_reg; // overflow traps
   wcs_res_t res_reg;
   wcs_res_t res_next;
   logic ovf_reg;
   logic ovf_next;
   logic [WCS_DATA_W-1:0] rdata_reg;
   logic [WCS_DATA_W-1:0] rdata_next;
   logic irq_reg;

   // datapath intermediates
   logic take; // request accepted this cycle
   logic [WCS_XLEN-1:0] imm_ext; // sign-extended immediate
   logic [WCS_WLEN-1:0] src_word; // low word of shift source
   logic [WCS_SHAMT_W-1:0] shift_dist; // chosen shift distance
   logic [WCS_WLEN-1:0] shift_word; // shifted word
   logic [WCS_WLEN:0] diff_ext; // 33-bit difference for overflow
   logic diff_ovf; // word overflow of subtract
   logic first_bad; // first source not a word value
   logic second_bad; // second source not a word value
   logic badop; // operand outside the defined range
   logic [WCS_EVT_W-1:0] events;
   logic status_hit;

   // word value test: bits 63 down to 31 all equal
   function automatic logic not_word(input logic [WCS_XLEN-1:0] v);
      not_word = !((&v[WCS_XLEN-1:WCS_WSIGN_BIT]) || !(|v[WCS_XLEN-1:WCS_WSIGN_BIT]));
   endfunction : not_word

   // sign-extend a 32-bit word to 64 bits
   function automatic logic [WCS_XLEN-1:0] sext_word(input logic [WCS_WLEN-1:0] w);
      sext_word = {{(WCS_XLEN-WCS_WLEN){w[WCS_WSIGN_BIT]}}, w};
   endfunction : sext_word

   // boolean result zero-filled to 64 bits
   function automatic logic [WCS_XLEN-1:0] set_bool(input logic b);
      set_bool = {{(WCS_XLEN-1){1'b0}}, b};
   endfunction : set_bool

   assign take = req.valid && ctrl_en_reg;

   // shared operand preparation
   always_comb begin
      imm_ext = {{(WCS_XLEN-WCS_IMM_W){req.immediate[WCS_IMM_W-1]}}, req.immediate};
      src_word = req.second_source[WCS_WLEN-1:0];
      // distance source depends on fixed or variable form
      unique case (req.op)
         WCS_OP_ARITH_RIGHT_SHIFT_VARIABLE,
         WCS_OP_LOGICAL_RIGHT_SHIFT_VARIABLE: begin
            shift_dist = req.first_source[WCS_SHAMT_W-1:0];
         end
         default: begin
            shift_dist = req.shift_amount_field;
         end
      endcase
      // arithmetic or logical fill
      unique case (req.op)
         WCS_OP_ARITH_RIGHT_SHIFT_FIXED,
         WCS_OP_ARITH_RIGHT_SHIFT_VARIABLE: begin
            shift_word = WCS_WLEN'($signed(src_word) >>> shift_dist);
         end
         default: begin
            shift_word = src_word >> shift_dist;
         end
      endcase
      // sign-extended 33-bit difference of the low words
      diff_ext = {req.first_source[WCS_WSIGN_BIT], req.first_source[WCS_WLEN-1:0]}
               - {req.second_source[WCS_WSIGN_BIT], req.second_source[WCS_WLEN-1:0]};
      diff_ovf = diff_ext[WCS_WLEN] ^ diff_ext[WCS_WSIGN_BIT];
      first_bad = not_word(req.first_source);
      second_bad = not_word(req.second_source);
   end

   // result selection per operation
   always_comb begin
      res_next = '0;
      ovf_next = 1'b0;
      badop = 1'b0;
      if (take) begin
         res_next.valid = 1'b1;
         res_next.write_en = 1'b1;
         res_next.dest_index = req.dest_index;
         unique case (req.op)
            // signed compares over full width
            WCS_OP_SIGNED_COMPARE_REGS: begin
               res_next.data = set_bool($signed(req.first_source)
                                        < $signed(req.second_source));
            end
            WCS_OP_SIGNED_COMPARE_IMM: begin
               res_next.data = set_bool($signed(req.first_source) < $signed(imm_ext));
            end
            // unsigned compares over full width
            WCS_OP_UNSIGNED_COMPARE_IMM: begin
               res_next.data = set_bool(req.first_source < imm_ext);
            end
            WCS_OP_UNSIGNED_COMPARE_REGS: begin
               res_next.data = set_bool(req.first_source < req.second_source);
            end
            // word shifts; bad source still yields the plain word result
            WCS_OP_ARITH_RIGHT_SHIFT_FIXED,
            WCS_OP_ARITH_RIGHT_SHIFT_VARIABLE,
            WCS_OP_LOGICAL_RIGHT_SHIFT_FIXED,
            WCS_OP_LOGICAL_RIGHT_SHIFT_VARIABLE: begin
               res_next.data = sext_word(shift_word);
               badop = second_bad;
            end
            // trapping subtract keeps the target on overflow
            WCS_OP_DIFFERENCE_TRAPPING: begin
               res_next.data = sext_word(diff_ext[WCS_WLEN-1:0]);
               res_next.write_en = !diff_ovf;
               ovf_next = diff_ovf;
               badop = first_bad || second_bad;
            end
            // wraparound subtract always writes, never traps
            WCS_OP_DIFFERENCE_WRAPAROUND: begin
               res_next.data = sext_word(diff_ext[WCS_WLEN-1:0]);
               badop = first_bad || second_bad;
            end
            // unknown code: retire without a write
            default: begin
               res_next.write_en = 1'b0;
            end
         endcase
      end
   end

   // result and overflow outputs
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         res_reg <= '0;
         ovf_reg <= 1'b0;
      end else begin
         res_reg <= res_next;
         ovf_reg <= ovf_next;
      end
   end

   // event vector and status read hit
   always_comb begin
      events = '0;
      events[WCS_EVT_OVF] = ovf_next;
      events[WCS_EVT_BADOP] = badop;
      events[WCS_EVT_DONE] = res_next.valid;
      status_hit = reg_rd && (reg_addr == WCS_STATUS_OFS);
      // read clears, a new event in the same cycle survives
      status_next = (status_hit ? '0 : status_reg) | events;
   end

   // sticky status
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         status_reg <= '0;
      end else begin
         status_reg <= status_next;
      end
   end

   // control and mask writes
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ctrl_en_reg <= WCS_CTRL_EN_RST;
         mask_reg <= WCS_MASK_RST;
      end else if (reg_wr) begin
         if (reg_addr == WCS_CTRL_OFS) begin
            ctrl_en_reg <= reg_wdata[WCS_CTRL_EN_BIT];
         end
         if (reg_addr == WCS_MASK_OFS) begin
            mask_reg <= reg_wdata[WCS_EVT_W-1:0];
         end
      end
   end

   // activity counters, cleared by any write to them
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         opcnt_reg <= '0;
         trapcnt_reg <= '0;
      end else begin
         if (reg_wr && (reg_addr == WCS_OPCNT_OFS)) begin
            opcnt_reg <= '0;
         end else if (res_next.valid) begin
            opcnt_reg <= opcnt_reg + 1'b1;
         end
         if (reg_wr && (reg_addr == WCS_TRAPCNT_OFS)) begin
            trapcnt_reg <= '0;
         end else if (ovf_next) begin
            trapcnt_reg <= trapcnt_reg + 1'b1;
         end
      end
   end

   // read data decode, unmapped reads return zero
   always_comb begin
      rdata_next = '0;
      if (reg_rd) begin
         unique case (reg_addr)
            WCS_CTRL_OFS: begin
               rdata_next[WCS_CTRL_EN_BIT] = ctrl_en_reg;
            end
            WCS_STATUS_OFS: begin
               rdata_next[WCS_EVT_W-1:0] = status_reg;
            end
            WCS_MASK_OFS: begin
               rdata_next[WCS_EVT_W-1:0] = mask_reg;
            end
            WCS_OPCNT_OFS: begin
               rdata_next = opcnt_reg;
            end
            WCS_TRAPCNT_OFS: begin
               rdata_next = trapcnt_reg;
            end
            default: begin
               rdata_next = '0;
            end
         endcase
      end
   end

   // read data register, valid only the cycle after the strobe
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rdata_reg <= '0;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // level interrupt from masked sticky status
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(status_next & mask_reg);
      end
   end

   assign res = res_reg;
   assign overflow_exc = ovf_reg;
   assign reg_rdata = rdata_reg;
   assign irq = irq_reg;

endmodule : wcs_slice

`default_nettype wire
